// ==== mcxi_regs.vh ====
// Register offsets, field positions, reset values and timing counts for the exception unit
`ifndef MCXI_REGS_VH
`define MCXI_REGS_VH
// Register offsets (word addresses on the plain register port)
`define MCXI_ADDR_CFG 4'h0
`define MCXI_ADDR_MSR 4'h1
`define MCXI_ADDR_SPC 4'h2
`define MCXI_ADDR_SST 4'h3
`define MCXI_ADDR_STAT 4'h4
`define MCXI_ADDR_NPC 4'h5
// Implementation configuration bits
`define MCXI_CFG_PIN 0
`define MCXI_CFG_CPAR 1
`define MCXI_CFG_APAR 2
`define MCXI_CFG_DPAR 3
`define MCXI_CFG_RESET 32'h0000_0000
// Machine state bits (bit 0 is the least significant here)
`define MCXI_MSR_LE 0
`define MCXI_VECTOR_BASE_SELECT 6
`define MCXI_DATA_TRANSLATE_BIT 4
`define MCXI_MSR_IR 5
`define MCXI_MC_ENABLE_BIT 12
`define MCXI_IRQ_ENABLE_BIT 15
`define MCXI_MSR_ILE 16
`define MCXI_MSR_RESET 32'h0000_0040
// Save-state mask: numbered 0 = msb, keep 0,5-9,16-31; clear 1-4,10-15
`define MCXI_SST_KEEP_FULL 32'h87c0_ffff
`define MCXI_SST_KEEP_EARLY 32'h0000_ffff
// Vectors
`define MCXI_VEC_MC 32'h0000_0200
`define MCXI_VEC_EXT 32'h0000_0500
`define MCXI_VEC_HI 32'hfff0_0000
// Freeze delay after halt entry, in cycles
`define MCXI_FREEZE_CYC 2
`endif

// ==== mcxi_unit.v ====
// Machine check, halt state and external interrupt exception unit
// Function
// [RULE1] Bus error or machine check starts exception
// [RULE2] Float data bus one clock after error
// [RULE3] Ignore machine check input unless pin-enabled
// [RULE4] Take machine check at once, save address
// [RULE5] Discard completed stores on machine check
// [RULE6] Machine check with enable clear halts
// [RULE7] Bus machine check beats instruction exceptions
// [RULE8] Assert halt status output on halt entry
// [RULE9] Halt on disabled check, input, protocol error
// [RULE10] Halt until reset, freeze within two cycles
// [RULE11] Parity, cache, error ack, pin raise check
// [RULE12] Config bits: pin, cache, address, data parity
// [RULE13] Error ack check is imprecise, unordered
// [RULE14] Exception only with all enables, else halt
// [RULE15] Block-zero check may wait for writeback
// [RULE16] Interrupt recognised only with enable set
// [RULE17] Taking interrupt leaves request line alone
// [RULE18] Requester holds line until exception taken
// [RULE19] Stop dispatch, drain, then take interrupt
// [RULE20] Requester negates line on handler acknowledge
// [RULE21] Interrupt vector offset 0x00500 from base
// [RULE22] Save-state bits cleared or copied by field
// [RULE23] Save next instruction address on interrupt
// [RULE24] Clear enable, translation; little-endian from IRQ_LITTLE_ENDIAN_BIT
`timescale 1ns/1ps
`include "mcxi_regs.vh"
module mcxi_unit #(
  parameter EARLY_VARIANT = 0 // 1 clears save-state bits 0 and 5-9
) (
  input wire mclk, // 50 MHz processor bus clock
  input wire rst, // Asynchronous reset, active high
  input wire transfer_error_ack, // Bus error from memory controller
  input wire machine_check_in, // External machine check input
  input wire external_halt_in, // External halt request
  input wire addr_parity_err, // Bus address parity error pulse
  input wire data_parity_err, // Bus data parity error pulse
  input wire cache_parity_err, // Cache parity error pulse
  input wire store_proto_err, // Direct-store protocol error pulse
  input wire irq_req, // External interrupt request, level
  input wire pipe_idle, // No instruction still executing
  input wire instr_exc_req, // Instruction exception pending
  input wire [31:0] next_pc, // Address of next instruction
  input wire [31:0] fault_pc, // Non-predicted address for checks
  input wire data_bus_drive, // Core wants to drive data bus
  input wire [3:0] reg_addr, // Register address
  input wire [31:0] reg_wdata, // Register write data
  input wire reg_wr, // Register write strobe
  input wire reg_rd, // Register read strobe
  output reg [31:0] reg_rdata, // Read data, cycle after strobe
  output wire data_bus_oe, // Data bus output enable
  output wire dispatch_stall, // Stop dispatching instructions
  output wire instr_exc_block, // Suppress instruction exception
  output reg store_queue_flush, // Discard completed stores, pulse
  output reg take_exc, // Exception taken, pulse
  output reg [31:0] fetch_addr, // New fetch address on take_exc
  output reg halt_status_out, // Halt state indicator
  output reg latch_freeze // Core latches frozen
);
  reg [31:0] impl_config_reg;
  reg [31:0] machine_state_reg;
  reg [31:0] save_pc_reg;
  reg [31:0] save_state_reg;
  reg bus_err_reg;
  reg irq_pend_reg;
  reg [1:0] freeze_cnt_reg;
  wire [31:0] base;
  wire [31:0] sst_keep;
  wire [31:0] msr_after;
  wire pin_check;
  wire par_check;
  wire mc_event;
  wire mc_take;
  wire halt_event;
  wire irq_take;

  // Pin check gated by configuration enable [RULE3] [RULE12]
  assign pin_check = machine_check_in & impl_config_reg[`MCXI_CFG_PIN];
  // Parity sources each gated by own enable [RULE11] [RULE12]
  assign par_check = (cache_parity_err & impl_config_reg[`MCXI_CFG_CPAR]) |
    (addr_parity_err & impl_config_reg[`MCXI_CFG_APAR]) |
    (data_parity_err & impl_config_reg[`MCXI_CFG_DPAR]);
  // Error ack is never tied to an instruction: imprecise [RULE13] [RULE1]
  assign mc_event = transfer_error_ack | pin_check | par_check;
  // Deferred block-zero errors arrive later as an error ack [RULE15]
  assign mc_take = mc_event & machine_state_reg[`MCXI_MC_ENABLE_BIT] & ~halt_status_out; // [RULE14]
  // Halt sources [RULE6] [RULE9]
  assign halt_event = (mc_event & ~machine_state_reg[`MCXI_MC_ENABLE_BIT]) |
    external_halt_in | store_proto_err;
  // Interrupt only when pipe drained and nothing higher pending [RULE19]
  assign irq_take = irq_pend_reg & pipe_idle & ~instr_exc_req & ~mc_take &
    ~halt_status_out & ~halt_event;
  // Bus check outranks the instruction's own exception [RULE7]
  assign instr_exc_block = mc_take | mc_event;
  assign dispatch_stall = irq_pend_reg | halt_status_out; // [RULE19] [RULE10]
  // Floating one clock after the error; data already in flight kept [RULE2]
  assign data_bus_oe = data_bus_drive & ~bus_err_reg & ~halt_status_out;
  assign base = machine_state_reg[`MCXI_VECTOR_BASE_SELECT] ? `MCXI_VEC_HI : 32'h0000_0000;
  assign sst_keep = EARLY_VARIANT ? `MCXI_SST_KEEP_EARLY : `MCXI_SST_KEEP_FULL;
  // New state: enable and translation off, LE from IRQ_LITTLE_ENDIAN_BIT [RULE24]
  assign msr_after = (machine_state_reg &
    ~((32'h1 << `MCXI_IRQ_ENABLE_BIT) | (32'h1 << `MCXI_DATA_TRANSLATE_BIT) | (32'h1 << `MCXI_MSR_IR) |
    (32'h1 << `MCXI_MSR_LE))) |
    ({31'h0, machine_state_reg[`MCXI_MSR_ILE]} << `MCXI_MSR_LE);

  // Bus error flag delays the float by one clock
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      bus_err_reg <= 1'b0;
    end else begin
      bus_err_reg <= transfer_error_ack | pin_check; // [RULE2]
    end
  end

  // Pending interrupt follows the line; request itself never cleared here
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      irq_pend_reg <= 1'b0;
    end else begin
      irq_pend_reg <= irq_req & machine_state_reg[`MCXI_IRQ_ENABLE_BIT] & ~irq_take; // [RULE16] [RULE17]
    end
  end

  // Halt state holds until reset; latches freeze two cycles in
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      halt_status_out <= 1'b0;
      freeze_cnt_reg <= 2'h0;
      latch_freeze <= 1'b0;
    end else if (halt_status_out) begin
      if (freeze_cnt_reg != `MCXI_FREEZE_CYC - 1) begin
        freeze_cnt_reg <= freeze_cnt_reg + 2'h1;
      end else begin
        latch_freeze <= 1'b1; // [RULE10]
      end
    end else if (halt_event) begin
      halt_status_out <= 1'b1; // [RULE8]
    end
  end

  // Exception entry, register file and saved state
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      impl_config_reg <= `MCXI_CFG_RESET;
      machine_state_reg <= `MCXI_MSR_RESET;
      save_pc_reg <= 32'h0000_0000;
      save_state_reg <= 32'h0000_0000;
      take_exc <= 1'b0;
      store_queue_flush <= 1'b0;
      fetch_addr <= 32'h0000_0000;
    end else begin
      take_exc <= 1'b0;
      store_queue_flush <= 1'b0;
      if (latch_freeze) begin
        take_exc <= 1'b0; // Frozen state kept for analysis
      end else if (mc_take) begin
        take_exc <= 1'b1; // [RULE4]
        store_queue_flush <= 1'b1; // [RULE5]
        save_pc_reg <= fault_pc; // [RULE4]
        save_state_reg <= machine_state_reg & sst_keep;
        machine_state_reg <= msr_after; // [RULE24]
        fetch_addr <= base | `MCXI_VEC_MC;
      end else if (irq_take) begin
        take_exc <= 1'b1;
        save_pc_reg <= next_pc; // [RULE23]
        save_state_reg <= machine_state_reg & sst_keep; // [RULE22]
        machine_state_reg <= msr_after; // [RULE24]
        fetch_addr <= base | `MCXI_VEC_EXT; // [RULE21]
      end else if (reg_wr) begin
        case (reg_addr)
          `MCXI_ADDR_CFG: impl_config_reg <= reg_wdata & 32'h0000_000f;
          `MCXI_ADDR_MSR: machine_state_reg <= reg_wdata;
          `MCXI_ADDR_SPC: save_pc_reg <= reg_wdata;
          `MCXI_ADDR_SST: save_state_reg <= reg_wdata;
          default: ;
        endcase
      end
    end
  end

  // Read data one cycle after the strobe; unmapped reads zero
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      case (reg_addr)
        `MCXI_ADDR_CFG: reg_rdata <= impl_config_reg;
        `MCXI_ADDR_MSR: reg_rdata <= machine_state_reg;
        `MCXI_ADDR_SPC: reg_rdata <= save_pc_reg;
        `MCXI_ADDR_SST: reg_rdata <= save_state_reg;
        `MCXI_ADDR_STAT: reg_rdata <= {28'h0, latch_freeze, halt_status_out,
          irq_pend_reg, bus_err_reg};
        `MCXI_ADDR_NPC: reg_rdata <= fetch_addr;
        default: reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end
endmodule // mcxi_unit

// ==== mcxi_unit_sva.sv ====
// Port-level checker for the exception unit
`timescale 1ns/1ps
module mcxi_unit_sva (
  input wire mclk, // Clock
  input wire rst, // Reset
  input wire transfer_error_ack, // Bus error
  input wire instr_exc_block, // Instruction exception suppressed
  input wire external_halt_in, // Halt input
  input wire store_proto_err, // Protocol error
  input wire data_bus_oe, // Bus drive
  input wire dispatch_stall, // Stall
  input wire store_queue_flush, // Flush
  input wire take_exc, // Taken
  input wire [31:0] fetch_addr, // Vector
  input wire halt_status_out, // Halted
  input wire latch_freeze // Frozen
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  property p_flush; store_queue_flush |-> take_exc; endproperty
  a_flush: assert property (p_flush) else $error("flush without take");
  property p_sticky; halt_status_out |=> halt_status_out; endproperty
  a_sticky: assert property (p_sticky) else $error("halt left");
  property p_freeze; $rose(halt_status_out) |-> ##2 latch_freeze; endproperty
  a_freeze: assert property (p_freeze) else $error("freeze late");
  property p_halt_in; external_halt_in || store_proto_err |=> halt_status_out; endproperty
  a_halt_in: assert property (p_halt_in) else $error("no halt");
  property p_float; transfer_error_ack |=> !data_bus_oe; endproperty
  a_float: assert property (p_float) else $error("bus still driven");
  property p_block; transfer_error_ack |-> instr_exc_block; endproperty
  a_block: assert property (p_block) else $error("bus check not first");
  property p_stall; halt_status_out |-> dispatch_stall && !data_bus_oe; endproperty
  a_stall: assert property (p_stall) else $error("halted but active");
  property p_vec; take_exc |-> fetch_addr[11:0] inside {12'h200, 12'h500}; endproperty
  a_vec: assert property (p_vec) else $error("bad vector");
  property p_dead; latch_freeze |-> !take_exc && !store_queue_flush; endproperty
  a_dead: assert property (p_dead) else $error("activity when frozen");
  c_mc: cover property (take_exc && store_queue_flush);
  c_irq: cover property (take_exc && !store_queue_flush);
  c_frz: cover property ($rose(latch_freeze));
  c_halt: cover property ($rose(halt_status_out));
endmodule // mcxi_unit_sva

// ==== mcxi_sys_model.sv ====
// Memory controller and interrupt controller seen by the unit
`timescale 1ns/1ps
module mcxi_sys_model (
  input wire mclk, // Clock
  input wire rst, // Reset
  input wire raise_irq, // Start request
  input wire ack_irq, // Handler acknowledge
  input wire bus_err_cmd, // Fail next transfer
  output reg irq_req, // Interrupt line
  output reg transfer_error_ack // Bus error
);
  // Request held until the handler acknowledges, never dropped early
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      irq_req <= 1'b0;
      transfer_error_ack <= 1'b0;
    end else begin
      irq_req <= (irq_req | raise_irq) & ~ack_irq;
      transfer_error_ack <= bus_err_cmd;
    end
  end
endmodule // mcxi_sys_model

// ==== mcxi_tb.sv ====
// Self-checking bench for the exception unit
`timescale 1ns/1ps
`include "mcxi_regs.vh"
`define CHK(a, b) begin checks_done = checks_done + 1; if ((a) !== (b)) begin num_errors = num_errors + 1; $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module testbench;
  reg mclk, rst, pipe_idle, data_bus_drive, reg_wr, reg_rd, got;
  reg [8:0] ev;
  reg [3:0] reg_addr;
  reg [31:0] reg_wdata, next_pc, fault_pc;
  wire irq_req, transfer_error_ack, data_bus_oe, dispatch_stall, store_queue_flush, take_exc;
  wire halt_status_out, latch_freeze;
  wire [31:0] reg_rdata, fetch_addr;
  integer num_errors, checks_done, k, n;
  mcxi_sys_model sysm (.mclk(mclk), .rst(rst), .raise_irq(ev[7]), .ack_irq(ev[8]),
    .bus_err_cmd(ev[6]), .irq_req(irq_req), .transfer_error_ack(transfer_error_ack));
  mcxi_unit dut (.mclk(mclk), .rst(rst), .transfer_error_ack(transfer_error_ack),
    .machine_check_in(ev[0]), .cache_parity_err(ev[1]), .addr_parity_err(ev[2]),
    .data_parity_err(ev[3]), .external_halt_in(ev[4]), .store_proto_err(ev[5]),
    .irq_req(irq_req), .pipe_idle(pipe_idle), .instr_exc_req(1'b0), .next_pc(next_pc),
    .fault_pc(fault_pc), .data_bus_drive(data_bus_drive), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .data_bus_oe(data_bus_oe), .dispatch_stall(dispatch_stall), .instr_exc_block(),
    .store_queue_flush(store_queue_flush), .take_exc(take_exc), .fetch_addr(fetch_addr),
    .halt_status_out(halt_status_out), .latch_freeze(latch_freeze));
  // Free-running 50 MHz clock
  always #10 mclk = ~mclk;
  task wr(input [3:0] a, input [31:0] d); begin
    @(posedge mclk); reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
    @(posedge mclk); reg_wr <= 1'b0; end endtask
  task rd(input [3:0] a, input [31:0] e); begin
    @(posedge mclk); reg_rd <= 1'b1; reg_addr <= a;
    @(posedge mclk); reg_rd <= 1'b0; #1; `CHK(reg_rdata, e) end endtask
  task pulse(input integer i); begin
    @(posedge mclk); ev <= 9'h001 << i; @(posedge mclk); ev <= 9'h000; end endtask
  // Bounded wait so a missing exception cannot hang the run
  task wait_take; begin
    #1; got = (take_exc === 1'b1);
    for (n = 0; n < 20 && !got; n = n + 1) begin @(posedge mclk); #1; got = (take_exc === 1'b1); end
  end endtask
  task rst_dut; begin
    @(posedge mclk); rst <= 1'b1; repeat (20) @(posedge mclk); rst <= 1'b0; end endtask
  task report_and_stop; begin
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  end endtask
  // Watchdog well past the expected run length
  initial begin #200000; num_errors = num_errors + 1; report_and_stop; end
  // Main sequence
  initial begin
    mclk = 0; rst = 1; ev = 0; reg_wr = 0; reg_rd = 0; reg_addr = 0; reg_wdata = 0;
    pipe_idle = 1; data_bus_drive = 1; next_pc = 32'h0000_1234; fault_pc = 32'h0000_2468;
    num_errors = 0; checks_done = 0;
    rst_dut;
    rd(`MCXI_ADDR_CFG, `MCXI_CFG_RESET);
    rd(`MCXI_ADDR_MSR, `MCXI_MSR_RESET);
    rd(4'hf, 32'h0);
    wr(`MCXI_ADDR_CFG, 32'hffff_ffff); rd(`MCXI_ADDR_CFG, 32'h0000_000f);
    $display("test reset done");
    pulse(7); wait_take; `CHK(got, 1'b0)
    @(posedge mclk); pipe_idle <= 1'b0; wr(`MCXI_ADDR_MSR, 32'h0001_8070);
    repeat (5) @(posedge mclk); #1; `CHK(dispatch_stall, 1'b1)
    @(posedge mclk); pipe_idle <= 1'b1; wait_take; `CHK(got, 1'b1)
    `CHK(fetch_addr, `MCXI_VEC_HI | `MCXI_VEC_EXT)
    `CHK(irq_req, 1'b1)
    rd(`MCXI_ADDR_SPC, next_pc);
    rd(`MCXI_ADDR_SST, 32'h0001_8070 & `MCXI_SST_KEEP_FULL);
    rd(`MCXI_ADDR_MSR, 32'h0001_0041); pulse(8);
    $display("test interrupt done");
    wr(`MCXI_ADDR_CFG, 32'h0); wr(`MCXI_ADDR_MSR, 32'h0000_1040); pulse(0);
    wait_take; `CHK(got, 1'b0)
    for (k = 0; k < 7; k = k + 1) if (k < 4 || k == 6) begin
      wr(`MCXI_ADDR_CFG, 32'h1 << k); wr(`MCXI_ADDR_MSR, 32'h0000_1040); pulse(k);
      wait_take; `CHK(got, 1'b1)
      `CHK(store_queue_flush, 1'b1)
      `CHK(fetch_addr, `MCXI_VEC_HI | `MCXI_VEC_MC)
      rd(`MCXI_ADDR_SPC, fault_pc);
    end
    $display("test machine check done");
    for (k = 4; k < 7; k = k + 1) begin
      rst_dut; pulse(k); repeat (4) @(posedge mclk); #1;
      `CHK(halt_status_out, 1'b1)
      `CHK(latch_freeze, 1'b1)
      wr(`MCXI_ADDR_CFG, 32'hf); rd(`MCXI_ADDR_CFG, 32'h0);
    end
    $display("test halt done");
    report_and_stop;
  end
endmodule // testbench
bind mcxi_unit mcxi_unit_sva u_sva (.mclk(mclk), .rst(rst),
  .transfer_error_ack(transfer_error_ack), .instr_exc_block(instr_exc_block),
  .external_halt_in(external_halt_in),
  .store_proto_err(store_proto_err), .data_bus_oe(data_bus_oe),
  .dispatch_stall(dispatch_stall), .store_queue_flush(store_queue_flush), .take_exc(take_exc),
  .fetch_addr(fetch_addr), .halt_status_out(halt_status_out), .latch_freeze(latch_freeze));
